// >>> rfap_params.svh
// constants for the register field access policy block
`ifndef RFAP_PARAMS_SVH
`define RFAP_PARAMS_SVH
`define RFAP_DATA_W 32
`define RFAP_ADDR_W 32
`define RFAP_NUM_REGS 4
`define RFAP_IDX_W 2
`define RFAP_IDX_LSB 2
`define RFAP_DWORD_MASK 32'h0000_0007
`define RFAP_HWORD_MASK 32'h0000_0001
`define RFAP_WORD_MASK 32'h0000_0003
`define RFAP_ALL_ZERO 32'h0000_0000
`define RFAP_ALL_ONE 32'hFFFF_FFFF
`endif

// >>> rfap_pkg.sv
// types for the register field access policy block
package rfap_pkg;
  typedef enum logic [2:0] {
    RFAP_RW = 3'h0,
    RFAP_READ_ONLY_FIELD = 3'h1,
    RFAP_READS_ZERO_WI = 3'h2,
    RFAP_READS_ZERO_ZKW = 3'h3,
    RFAP_READS_ONE_OKW = 3'h4,
    RFAP_RESERVED = 3'h5,
    RFAP_KEEP_UNALTERED = 3'h6
  } rfap_class_e;
  typedef enum logic [1:0] {
    RFAP_SZ_BYTE = 2'h0,
    RFAP_SZ_HALF = 2'h1,
    RFAP_SZ_WORD = 2'h2,
    RFAP_SZ_DWORD = 2'h3
  } rfap_size_e;
endpackage : rfap_pkg

// >>> rfap_lane.sv
// little-endian byte lane placement and alignment tests
`timescale 1ns/1ps
`default_nettype none
`include "rfap_params.svh"
module rfap_lane (
  input wire logic [`RFAP_ADDR_W-1:0] addr,
  input wire rfap_pkg::rfap_size_e size,
  input wire logic [`RFAP_DATA_W-1:0] wdata_in,
  output logic [`RFAP_DATA_W-1:0] wdata_lane,
  output logic [3:0] strobe,
  output logic dword_aligned,
  output logic hword_aligned,
  output logic access_aligned
);
  import rfap_pkg::*;
  always_comb begin
    dword_aligned = (addr & `RFAP_DWORD_MASK) == `RFAP_ALL_ZERO;
    hword_aligned = (addr & `RFAP_HWORD_MASK) == `RFAP_ALL_ZERO;
    case (size)
      RFAP_SZ_BYTE: access_aligned = 1'b1;
      RFAP_SZ_HALF: access_aligned = hword_aligned;
      RFAP_SZ_WORD: access_aligned = (addr & `RFAP_WORD_MASK) == `RFAP_ALL_ZERO;
      RFAP_SZ_DWORD: access_aligned = dword_aligned;
      default: access_aligned = 1'b0;
    endcase
    // lowest address goes to least significant lane
    case (size)
      RFAP_SZ_BYTE: begin
        wdata_lane = {4{wdata_in[7:0]}};
        strobe = 4'h1 << addr[1:0];
      end
      RFAP_SZ_HALF: begin
        wdata_lane = {2{wdata_in[15:0]}};
        strobe = addr[1] ? 4'hC : 4'h3;
      end
      default: begin
        wdata_lane = wdata_in;
        strobe = 4'hF;
      end
    endcase
  end
endmodule : rfap_lane
`default_nettype wire

// >>> rfap_bank.sv
// register bank applying per-bit field access policies
`timescale 1ns/1ps
`default_nettype none
`include "rfap_params.svh"
module rfap_bank #(
  parameter int NUM_REGS = `RFAP_NUM_REGS,
  parameter logic [NUM_REGS*`RFAP_DATA_W-1:0] WRITABLE_MASK = {NUM_REGS{32'h0000_00FF}},
  parameter logic [NUM_REGS*`RFAP_DATA_W-1:0] READ_ONLY_MASK = {NUM_REGS{32'h0000_FF00}},
  parameter logic [NUM_REGS*`RFAP_DATA_W-1:0] READS_ONE_MASK = {NUM_REGS{32'h00FF_0000}},
  parameter logic [NUM_REGS*`RFAP_DATA_W-1:0] RESET_VALUE = {NUM_REGS{32'h0000_0000}}
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [`RFAP_ADDR_W-1:0] addr,
  input wire rfap_pkg::rfap_size_e size,
  input wire logic [`RFAP_DATA_W-1:0] wdata,
  input wire logic [NUM_REGS*`RFAP_DATA_W-1:0] ro_status,
  output logic [`RFAP_DATA_W-1:0] rdata,
  output logic ack,
  output logic misaligned,
  output logic [NUM_REGS*`RFAP_DATA_W-1:0] reg_value
);
  import rfap_pkg::*;
  logic [`RFAP_DATA_W-1:0] store [NUM_REGS];
  logic [`RFAP_DATA_W-1:0] wdata_lane;
  logic [3:0] strobe;
  logic access_aligned;
  logic [`RFAP_IDX_W-1:0] idx;
  logic hit;
  assign idx = addr[`RFAP_IDX_LSB +: `RFAP_IDX_W];
  // everything above the register index must be zero, or the access is unmapped
  assign hit = (addr[`RFAP_ADDR_W-1:`RFAP_IDX_LSB+`RFAP_IDX_W] == '0) && (int'(idx) < NUM_REGS);
  // fixed-value masks of register zero, used by the checks below
  logic [`RFAP_DATA_W-1:0] fixed_ones0;
  logic [`RFAP_DATA_W-1:0] fixed_zero0;
  assign fixed_ones0 = READS_ONE_MASK[`RFAP_DATA_W-1:0] & ~WRITABLE_MASK[`RFAP_DATA_W-1:0]
                     & ~READ_ONLY_MASK[`RFAP_DATA_W-1:0];
  assign fixed_zero0 = ~(WRITABLE_MASK[`RFAP_DATA_W-1:0] | READ_ONLY_MASK[`RFAP_DATA_W-1:0]
                     | READS_ONE_MASK[`RFAP_DATA_W-1:0]);

  rfap_lane u_lane (
    .addr(addr),
    .size(size),
    .wdata_in(wdata),
    .wdata_lane(wdata_lane),
    .strobe(strobe),
    .dword_aligned(),
    .hword_aligned(),
    .access_aligned(access_aligned)
  );

  function automatic logic [`RFAP_DATA_W-1:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // view of one register as software sees it; non-writable, non-status bits are fixed
  function automatic logic [`RFAP_DATA_W-1:0] read_view(input int i);
    logic [`RFAP_DATA_W-1:0] w;
    logic [`RFAP_DATA_W-1:0] r;
    logic [`RFAP_DATA_W-1:0] o;
    w = WRITABLE_MASK[i*`RFAP_DATA_W +: `RFAP_DATA_W];
    r = READ_ONLY_MASK[i*`RFAP_DATA_W +: `RFAP_DATA_W];
    o = READS_ONE_MASK[i*`RFAP_DATA_W +: `RFAP_DATA_W] & ~w & ~r;
    // reserved and undefined-read positions read zero rather than junk
    read_view = (store[i] & w) | (ro_status[i*`RFAP_DATA_W +: `RFAP_DATA_W] & r) | o;
  endfunction : read_view

  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          store[g] <= RESET_VALUE[g*`RFAP_DATA_W +: `RFAP_DATA_W] & WRITABLE_MASK[g*`RFAP_DATA_W +: `RFAP_DATA_W];
        end else if (req && wr && hit && access_aligned && int'(idx) == g) begin
          // only writable bits in the strobed lanes take data
          store[g] <= (store[g] & ~(WRITABLE_MASK[g*`RFAP_DATA_W +: `RFAP_DATA_W] & lane_mask(strobe)))
                    | (wdata_lane & WRITABLE_MASK[g*`RFAP_DATA_W +: `RFAP_DATA_W] & lane_mask(strobe));
        end
      end
      assign reg_value[g*`RFAP_DATA_W +: `RFAP_DATA_W] = read_view(g);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      misaligned <= 1'b0;
    end else begin
      ack <= req;
      misaligned <= req && !access_aligned;
    end
  end

  // unmapped or misaligned reads return zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= `RFAP_ALL_ZERO;
    end else if (req && !wr) begin
      rdata <= (hit && access_aligned) ? read_view(int'(idx)) : `RFAP_ALL_ZERO;
    end
  end

  // field classes fixed by masks: no write can reach them
  AST_FIXED_BITS_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr |=> ((store[0] & ~WRITABLE_MASK[`RFAP_DATA_W-1:0]) == `RFAP_ALL_ZERO))
    else $error("fixed bits of register zero changed");
  AST_READS_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && !wr && hit && access_aligned |=> ((rdata & READS_ONE_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W]
      & ~WRITABLE_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W]
      & ~READ_ONLY_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W])
      == (READS_ONE_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W]
      & ~WRITABLE_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W]
      & ~READ_ONLY_MASK[int'($past(idx))*`RFAP_DATA_W +: `RFAP_DATA_W])))
    else $error("reads-one field did not read as ones");
  AST_MISALIGNED_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr && !access_aligned |=> $stable(store[0]) && $stable(store[1]))
    else $error("misaligned write changed a register");
  AST_READ_ONLY_KEEP: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 ((reg_value[`RFAP_DATA_W-1:0] & READ_ONLY_MASK[`RFAP_DATA_W-1:0])
      == (ro_status[`RFAP_DATA_W-1:0] & READ_ONLY_MASK[`RFAP_DATA_W-1:0])))
    else $error("read-only bits do not follow status");
  AST_BYTE_LOW_LANE: assert property (@(posedge clk_sys) disable iff (!resetn)
    size == RFAP_SZ_BYTE && addr[1:0] == 2'b00 |-> strobe == 4'h1 && wdata_lane[7:0] == wdata[7:0])
    else $error("byte at word address not in low lane");
  AST_HALF_BYTE_LOW: assert property (@(posedge clk_sys) disable iff (!resetn)
    size == RFAP_SZ_BYTE && addr[1:0] == 2'b10 |-> strobe == 4'h4)
    else $error("byte at halfword address not low byte of halfword");
  AST_HALF_LOW_LANE: assert property (@(posedge clk_sys) disable iff (!resetn)
    size == RFAP_SZ_HALF && addr[1:0] == 2'b00 |-> strobe == 4'h3)
    else $error("halfword at word address not in low lane");
  AST_ACK_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && !wr && !hit |=> ack && rdata == `RFAP_ALL_ZERO)
    else $error("unmapped read did not return zero");
  // fixed positions are checked on the live view, so a broken mask shows at once
  AST_ZERO_BITS_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_value[`RFAP_DATA_W-1:0] & fixed_zero0) == `RFAP_ALL_ZERO)
    else $error("reads-zero bits of register zero not zero");
  AST_ONE_BITS_READ_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_value[`RFAP_DATA_W-1:0] & fixed_ones0) == fixed_ones0)
    else $error("reads-one bits of register zero not one");
  AST_RESERVED_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_value[`RFAP_DATA_W +: `RFAP_DATA_W] & ~(WRITABLE_MASK[`RFAP_DATA_W +: `RFAP_DATA_W]
      | READ_ONLY_MASK[`RFAP_DATA_W +: `RFAP_DATA_W] | READS_ONE_MASK[`RFAP_DATA_W +: `RFAP_DATA_W]))
      == `RFAP_ALL_ZERO)
    else $error("reserved bits of register one not zero");
  AST_UNDEFINED_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_value[2*`RFAP_DATA_W +: `RFAP_DATA_W] & ~(WRITABLE_MASK[2*`RFAP_DATA_W +: `RFAP_DATA_W]
      | READ_ONLY_MASK[2*`RFAP_DATA_W +: `RFAP_DATA_W] | READS_ONE_MASK[2*`RFAP_DATA_W +: `RFAP_DATA_W]))
      == `RFAP_ALL_ZERO)
    else $error("undefined-read bits of register two not zero");
  AST_KEEP_CLASS_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_value[3*`RFAP_DATA_W +: `RFAP_DATA_W] & ~(WRITABLE_MASK[3*`RFAP_DATA_W +: `RFAP_DATA_W]
      | READ_ONLY_MASK[3*`RFAP_DATA_W +: `RFAP_DATA_W] | READS_ONE_MASK[3*`RFAP_DATA_W +: `RFAP_DATA_W]))
      == `RFAP_ALL_ZERO)
    else $error("zero-or-keep bits of register three not zero");
  AST_WRITE_KEEPS_ZERO_BITS: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr |=> $stable(reg_value[`RFAP_DATA_W-1:0] & fixed_zero0))
    else $error("write changed a keep-class field");
  // a full-word write to register zero must land on every one of its writable bits
  AST_MASKED_WRITE_LANDS: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr && hit && access_aligned && idx == 2'h0 && size == RFAP_SZ_WORD
      |=> (store[0] & WRITABLE_MASK[`RFAP_DATA_W-1:0]) == ($past(wdata) & WRITABLE_MASK[`RFAP_DATA_W-1:0]))
    else $error("writable bits did not take the written word");
  // holds for the default masks only: just the low lane is writable there
  AST_NARROW_WRITE_OTHER_LANE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr && idx == 2'h0 && size == RFAP_SZ_BYTE && addr[1:0] != 2'b00 |=> $stable(store[0]))
    else $error("byte write off the low lane changed register zero");
  AST_MISALIGNED_PULSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && !access_aligned |=> misaligned && ack)
    else $error("misaligned access not flagged");
  AST_ALIGNED_NO_PULSE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && access_aligned |=> !misaligned)
    else $error("aligned access flagged as misaligned");
  AST_DWORD_ODD_WORD: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && size == RFAP_SZ_DWORD && addr[2] |=> misaligned)
    else $error("doubleword at odd word not flagged");
  AST_HALF_ODD_BYTE: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && size == RFAP_SZ_HALF && addr[0] |=> misaligned)
    else $error("halfword at odd byte not flagged");
  AST_HALF_HIGH_LANE: assert property (@(posedge clk_sys) disable iff (!resetn)
    size == RFAP_SZ_HALF && addr[1:0] == 2'b10 |-> strobe == 4'hC && wdata_lane[31:16] == wdata[15:0])
    else $error("halfword at upper half not in upper lanes");
  AST_BYTE_ODD_LANE: assert property (@(posedge clk_sys) disable iff (!resetn)
    size == RFAP_SZ_BYTE && addr[1:0] == 2'b01 |-> strobe == 4'h2 && wdata_lane[15:8] == wdata[7:0])
    else $error("byte at odd address not in its lane");
  AST_UNMAPPED_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr && !hit |=> $stable(store[0]) && $stable(store[1]) && $stable(store[2]) && $stable(store[3]))
    else $error("unmapped write changed a register");
  AST_MISALIGNED_WRITE_ALL: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && wr && !access_aligned |=> $stable(store[2]) && $stable(store[3]))
    else $error("misaligned write changed an upper register");
  // an aligned read of register zero returns the whole register exactly as the live view showed it
  AST_READ_WHOLE_REG0: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && !wr && hit && access_aligned && idx == 2'h0 |=> rdata == $past(reg_value[`RFAP_DATA_W-1:0]))
    else $error("read of register zero differs from its view");
  AST_MISALIGNED_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!resetn)
    req && !wr && !access_aligned |=> rdata == `RFAP_ALL_ZERO)
    else $error("misaligned read did not return zero");
endmodule : rfap_bank
`default_nettype wire

// >>> rfap_bank_tb_top.sv
// self-checking testbench for the field access policy register bank
`timescale 1ns/1ps
`default_nettype none
`include "rfap_params.svh"
module rfap_bank_tb_top;
  import rfap_pkg::*;
  typedef struct {logic rd; logic mis; logic [31:0] d; int i; logic [7:0] b;} rfap_note_s;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = 32'h0;
  rfap_size_e size = RFAP_SZ_WORD;
  logic [31:0] wdata = 32'h0;
  logic [127:0] ro_status = 128'h0;
  logic [31:0] rdata;
  logic ack;
  logic misaligned;
  logic [127:0] reg_value;
  logic [7:0] st [4];
  rfap_note_s notes[$];
  rfap_note_s nt;
  int n_fail = 0;
  int tests_run = 0;
  rfap_bank u_dut (.clk_sys(clk_sys), .resetn(resetn), .req(req), .wr(wr), .addr(addr), .size(size),
    .wdata(wdata), .ro_status(ro_status), .rdata(rdata), .ack(ack), .misaligned(misaligned), .reg_value(reg_value));
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // model: only lane 0 is writable, lane 1 from status, lane 2 fixed ones, lane 3 zero
  task automatic acc(input logic w, input logic [31:0] a, input rfap_size_e sz, input logic [31:0] d);
    rfap_note_s n;
    logic al;
    int i;
    @(negedge clk_sys);
    // status changes only here, so it stands still until the read samples it
    ro_status = {$urandom, $urandom, $urandom, $urandom};
    al = !((sz == RFAP_SZ_HALF && a[0]) || (sz == RFAP_SZ_WORD && a[1:0] != 2'h0) ||
      (sz == RFAP_SZ_DWORD && a[2:0] != 3'h0));
    i = int'(a[3:2]);
    n.rd = !w;
    n.mis = !al;
    n.d = (al && a[31:4] == 28'h0) ? {8'h00, 8'hFF, ro_status[i*32+8 +: 8], st[i]} : 32'h0;
    if (w && al && a[31:4] == 28'h0 && (sz != RFAP_SZ_BYTE || a[1:0] == 2'h0) && (sz != RFAP_SZ_HALF || !a[1])) begin
      st[i] = d[7:0];
    end
    n.i = i;
    n.b = st[i];
    req = 1'b1;
    wr = w;
    addr = a;
    size = sz;
    wdata = d;
    notes.push_back(n);
  endtask : acc
  task automatic drain();
    @(negedge clk_sys);
    req = 1'b0;
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(negedge clk_sys);
    if (notes.size() != 0) begin
      n_fail++;
      $display("ERROR ack expected %0d more seen 0", notes.size());
      summarize();
    end
  endtask : drain
  task automatic summarize();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  always @(negedge clk_sys) begin
    if (ack === 1'b1) begin
      tests_run++;
      if (notes.size() == 0) begin
        n_fail++;
        $display("ERROR ack expected 0 seen 1");
      end else begin
        nt = notes.pop_front();
        if ({reg_value[nt.i*32+16 +: 16], reg_value[nt.i*32 +: 8]} !== {16'h00FF, nt.b}) begin
          n_fail++;
          $display("ERROR reg_value expected %h seen %h", {16'h00FF, nt.b},
            {reg_value[nt.i*32+16 +: 16], reg_value[nt.i*32 +: 8]});
        end
        if (misaligned !== nt.mis) begin
          n_fail++;
          $display("ERROR misaligned expected %b seen %b", nt.mis, misaligned);
        end
        if (nt.rd && rdata !== nt.d) begin
          n_fail++;
          $display("ERROR rdata expected %h seen %h", nt.d, rdata);
        end
      end
    end
  end
  initial begin
    void'($urandom(95));
    for (int i = 0; i < 4; i++) st[i] = 8'h00;
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    for (int r = 0; r < 2; r++) begin
      // reads first: stored bits must come back at their reset value
      for (int i = 0; i < 4; i++) acc(1'b0, 32'(4 * i), RFAP_SZ_WORD, 32'h0);
      for (int i = 0; i < 4; i++) acc(1'b1, 32'(4 * i), RFAP_SZ_WORD, 32'hFFFF_FFFF);
      for (int i = 0; i < 4; i++) acc(1'b0, 32'(4 * i + 2), RFAP_SZ_BYTE, 32'h0);
      // well-behaved software: read, change the low field only, write the rest back as read
      for (int i = 0; i < 4; i++) begin
        acc(1'b0, 32'(4 * i), RFAP_SZ_WORD, 32'h0);
        acc(1'b1, 32'(4 * i), RFAP_SZ_WORD, {16'h00FF, ro_status[i*32+8 +: 8], 8'($urandom)});
      end
      // random mix covers lanes, sizes, unmapped places and back-to-back traffic
      for (int n = 0; n < 400; n++) begin
        acc(1'($urandom), 32'($urandom % 24) | (($urandom % 16 == 0) ? 32'h8000_0000 : 32'h0),
          rfap_size_e'(2'($urandom)), $urandom);
        if ($urandom % 4 == 0) drain();
      end
      drain();
      // second reset in mid-run must clear the writable lane again
      resetn = 1'b0;
      for (int i = 0; i < 4; i++) st[i] = 8'h00;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
    end
    summarize();
  end
endmodule : rfap_bank_tb_top
`default_nettype wire
